//--- rtl/tfi_pkg.sv
// shared constants and types for the translation fence block
package tfi_pkg;
    // instruction encoding of the fence
    localparam logic [6:0] OP_SYSTEM = 7'h73;
    localparam logic [2:0] F3_PRIV   = 3'h0;
    localparam logic [6:0] F7_FENCE  = 7'h09;
    localparam logic [4:0] REG_X0    = 5'h00;
    localparam int         F7_HI     = 31;
    localparam int         F7_LO     = 25;
    localparam int         RS2_HI    = 24;
    localparam int         RS2_LO    = 20;
    localparam int         RS1_HI    = 19;
    localparam int         RS1_LO    = 15;
    localparam int         F3_HI     = 14;
    localparam int         F3_LO     = 12;
    localparam int         RD_HI     = 11;
    localparam int         RD_LO     = 7;
    localparam int         OP_HI     = 6;
    localparam int         OP_LO     = 0;

    // address geometry of the 39-bit paged scheme on a 64-bit hart
    localparam int supervisor_word_width = 64;
    localparam int VA_W                  = 39;
    localparam int PAGE_OFS              = 12;
    localparam int VPN_W                 = VA_W - PAGE_OFS;
    localparam int PPN_W                 = 44;
    localparam int MAX_SPACE_ID_W32      = 9;
    localparam int max_space_id_width    = 16;

    // register map, byte addresses
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_SPACE  = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h08;
    localparam logic [7:0] A_COUNT  = 8'h0c;

    // control register fields
    localparam int C_PAGED = 0;
    localparam int C_SUAP  = 1;
    localparam int C_MXR   = 2;
    localparam int C_WIDE  = 3;
    localparam int C_W     = 4;
    localparam logic [C_W-1:0] CTRL_RST = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DRAIN = 2'b01,
        ST_FLUSH = 2'b10
    } tfi_st_t;

    typedef struct packed {
        logic                          valid;
        logic                          global;
        logic                          leaf;
        logic [max_space_id_width-1:0] space;
        logic [VPN_W-1:0]              vpn;
        logic [PPN_W-1:0]              ppn;
    } tfi_entry_t;
endpackage

//--- rtl/tfi_dec_if.sv
// carrier between the fence decoder and the fence engine
`timescale 1ns/1ps
interface tfi_dec_if;
    logic [31:0]                               instr;
    logic [tfi_pkg::supervisor_word_width-1:0] rs1_val;
    logic [tfi_pkg::supervisor_word_width-1:0] rs2_val;
    logic                                      is_fence;
    logic                                      rs1_zero;
    logic                                      rs2_zero;
    logic                                      va_ok;
    logic [tfi_pkg::VPN_W-1:0]                 vpn;
    logic [tfi_pkg::max_space_id_width-1:0]    space;

    modport dec (
        input  instr, rs1_val, rs2_val,
        output is_fence, rs1_zero, rs2_zero, va_ok, vpn, space
    );
    modport eng (
        output instr, rs1_val, rs2_val,
        input  is_fence, rs1_zero, rs2_zero, va_ok, vpn, space
    );
endinterface

//--- rtl/tfi_decode.sv
// decoder of the fence instruction and its operands
`timescale 1ns/1ps
module tfi_decode #(
    parameter int IMPL_W = tfi_pkg::max_space_id_width
) (
    tfi_dec_if.dec d
);
    localparam int HI_W = tfi_pkg::supervisor_word_width - tfi_pkg::VA_W + 1;
    localparam logic [tfi_pkg::max_space_id_width-1:0] MASK =
        tfi_pkg::max_space_id_width'((17'h1 << IMPL_W) - 17'h1);

    logic [HI_W-1:0] hi;

    always_comb begin
        hi = d.rs1_val[tfi_pkg::supervisor_word_width-1:tfi_pkg::VA_W-1];
        d.is_fence = (d.instr[tfi_pkg::OP_HI:tfi_pkg::OP_LO] == tfi_pkg::OP_SYSTEM)
                   && (d.instr[tfi_pkg::F3_HI:tfi_pkg::F3_LO] == tfi_pkg::F3_PRIV)
                   && (d.instr[tfi_pkg::F7_HI:tfi_pkg::F7_LO] == tfi_pkg::F7_FENCE)
                   && (d.instr[tfi_pkg::RD_HI:tfi_pkg::RD_LO] == tfi_pkg::REG_X0);
        d.rs2_zero = d.instr[tfi_pkg::RS2_HI:tfi_pkg::RS2_LO] == tfi_pkg::REG_X0;
        d.rs1_zero = d.instr[tfi_pkg::RS1_HI:tfi_pkg::RS1_LO] == tfi_pkg::REG_X0;
        d.va_ok    = (&hi) || !(|hi);
        d.vpn      = d.rs1_val[tfi_pkg::VA_W-1:tfi_pkg::PAGE_OFS];
        d.space    = d.rs2_val[tfi_pkg::max_space_id_width-1:0] & MASK;
    end
endmodule

//--- rtl/tfi_fence.sv
// translation fence engine with the hart-private translation cache
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
// How it works
// - Fence is SYSTEM opcode, privileged funct3, rd zero; rs2 at 24:20, rs1 at 19:15.
// - Both operands x0: order everything and drop every cached entry.
// - Only identifier given: drop that space's entries, global entries survive.
// - Only address given: drop leaf entries for that page in every space.
// - Both given: drop matching leaf entries of that space, never global ones.
// - Non-canonical address operand: fence does nothing and raises nothing.
// - Identifier bits above the implemented width are ignored.
// - Over-fencing is allowed; a control bit widens every fence but a non-canonical-address one to full.
// - Earlier visible stores drain before later page-table reads.
// - Only this hart's cache is touched; nothing leaves the block.
// - Entries change only by fill or fence, so old or new mapping is seen.
// - Invalid entries may be cached; this cache chooses not to.
// - Fills need a valid entry; faults only for non-speculative walks.
// - Access controls, mode and identifier act at once without a fence.
// - Cache is private; identifiers only mean something on this hart.
// - With paging unsupported the fence raises an illegal instruction.
// - Maximum identifier width is 9 for 32-bit and 16 for wider schemes.
// - Global mark means present in all spaces, inherited below non-leaf entries.
module tfi_fence #(
    parameter int   ENTRIES = 8,
    parameter int   IMPL_W  = tfi_pkg::max_space_id_width,
    parameter logic PAGING  = 1'b1
) (
    // clock and reset
    input  wire logic                                      clk_i,
    input  wire logic                                      rst_i,
    // wishbone slave
    input  wire logic                                      wb_cyc_i,
    input  wire logic                                      wb_stb_i,
    input  wire logic                                      wb_we_i,
    input  wire logic [7:0]                                wb_adr_i,
    input  wire logic [3:0]                                wb_sel_i,
    input  wire logic [31:0]                               wb_dat_i,
    output logic      [31:0]                               wb_dat_o,
    output logic                                           wb_ack_o,
    // fence request from the pipeline
    input  wire logic                                      fence_valid_i,
    input  wire logic [31:0]                               fence_instr_i,
    input  wire logic [tfi_pkg::supervisor_word_width-1:0] fence_rs1_i,
    input  wire logic [tfi_pkg::supervisor_word_width-1:0] fence_rs2_i,
    input  wire logic                                      store_drained_i,
    output logic                                           fence_ready_o,
    output logic                                           fence_done_o,
    output logic                                           illegal_o,
    output logic                                           stall_o,
    // translation lookup
    input  wire logic                                      lk_valid_i,
    input  wire logic [tfi_pkg::VPN_W-1:0]                 lk_vpn_i,
    output logic                                           lk_ready_o,
    output logic                                           lk_valid_o,
    output logic                                           lk_hit_o,
    output logic      [tfi_pkg::PPN_W-1:0]                 lk_ppn_o,
    // fill from the walker
    input  wire logic                                      fill_valid_i,
    input  wire logic [tfi_pkg::VPN_W-1:0]                 fill_vpn_i,
    input  wire logic [tfi_pkg::PPN_W-1:0]                 fill_ppn_i,
    input  wire logic                                      fill_v_i,
    input  wire logic                                      fill_global_i,
    input  wire logic                                      fill_leaf_i,
    input  wire logic                                      fill_spec_i,
    output logic                                           fill_ready_o,
    output logic                                           page_fault_o,
    // live translation controls
    output logic                                           paged_o,
    output logic                                           supervisor_user_access_permit_o,
    output logic                                           make_executable_readable_o,
    output logic      [tfi_pkg::max_space_id_width-1:0]    space_o
);
    localparam int PTR_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
    localparam int SP_W  = tfi_pkg::max_space_id_width;

    typedef struct packed {
        tfi_pkg::tfi_st_t                  st;
        tfi_pkg::tfi_entry_t [ENTRIES-1:0] tlb;
        logic [PTR_W-1:0]                  rr;
        logic [tfi_pkg::C_W-1:0]           ctrl;
        logic [SP_W-1:0]                   space;
        logic [15:0]                       count;
        logic                              ack;
        logic [31:0]                       rdata;
        logic                              use_va;
        logic                              use_sp;
        logic [tfi_pkg::VPN_W-1:0]         f_vpn;
        logic [SP_W-1:0]                   f_sp;
        logic                              done;
        logic                              illegal;
        logic                              pf;
        logic                              lk_v;
        logic                              lk_hit;
        logic [tfi_pkg::PPN_W-1:0]         lk_ppn;
    } tfi_regs_t;

    tfi_regs_t s_q;
    tfi_regs_t s_d;
    tfi_dec_if dec ();

    logic [ENTRIES-1:0] valid_vec;
    logic [ENTRIES-1:0] gvalid_vec;

    assign dec.instr   = fence_instr_i;
    assign dec.rs1_val = fence_rs1_i;
    assign dec.rs2_val = fence_rs2_i;

    tfi_decode #(.IMPL_W(IMPL_W)) u_dec (
        .d (dec)
    );

    function automatic logic [31:0] f_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // entry chosen for removal by the latched fence scope
    function automatic logic f_kill(input tfi_pkg::tfi_entry_t e, input logic use_va, input logic use_sp,
                                    input logic [tfi_pkg::VPN_W-1:0] vpn, input logic [SP_W-1:0] sp);
        logic hit_sp;
        logic hit_va;
        hit_sp = !use_sp || (!e.global && (e.space == sp));
        hit_va = !use_va || (e.leaf && (e.vpn == vpn));
        return hit_sp && hit_va;
    endfunction

    function automatic logic f_hit(input tfi_pkg::tfi_entry_t e, input logic [tfi_pkg::VPN_W-1:0] vpn,
                                   input logic [SP_W-1:0] sp);
        return e.valid && e.leaf && (e.vpn == vpn) && (e.global || (e.space == sp));
    endfunction

    always_comb begin
        s_d         = s_q;
        s_d.ack     = 1'b0;
        s_d.done    = 1'b0;
        s_d.illegal = 1'b0;
        s_d.pf      = 1'b0;
        s_d.lk_v    = 1'b0;
        for (int i = 0; i < ENTRIES; i++) begin
            valid_vec[i]  = s_q.tlb[i].valid;
            gvalid_vec[i] = s_q.tlb[i].valid && s_q.tlb[i].global;
        end
        // register access, one wait state
        if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
            s_d.ack   = 1'b1;
            s_d.rdata = '0;
            unique case (wb_adr_i)
                tfi_pkg::A_CTRL: begin
                    s_d.rdata = 32'(s_q.ctrl);
                    if (wb_we_i) begin
                        s_d.ctrl = tfi_pkg::C_W'(f_merge(32'(s_q.ctrl), wb_dat_i, wb_sel_i));
                    end
                end
                tfi_pkg::A_SPACE: begin
                    s_d.rdata = 32'(s_q.space);
                    if (wb_we_i) begin
                        s_d.space = SP_W'(f_merge(32'(s_q.space), wb_dat_i, wb_sel_i));
                    end
                end
                tfi_pkg::A_STATUS: s_d.rdata = 32'({valid_vec, s_q.st != tfi_pkg::ST_IDLE});
                tfi_pkg::A_COUNT:  s_d.rdata = 32'(s_q.count);
                default:           s_d.rdata = '0;
            endcase
        end
        // lookups use the live mode and identifier
        if (lk_valid_i && s_q.st == tfi_pkg::ST_IDLE) begin
            s_d.lk_v   = 1'b1;
            s_d.lk_hit = !s_q.ctrl[tfi_pkg::C_PAGED];
            s_d.lk_ppn = tfi_pkg::PPN_W'(lk_vpn_i);
            if (s_q.ctrl[tfi_pkg::C_PAGED]) begin
                s_d.lk_ppn = '0;
                for (int i = 0; i < ENTRIES; i++) begin
                    if (f_hit(s_q.tlb[i], lk_vpn_i, s_q.space)) begin
                        s_d.lk_hit = 1'b1;
                        s_d.lk_ppn = s_q.tlb[i].ppn;
                    end
                end
            end
        end
        // fills; invalid entries are not kept
        if (fill_valid_i && s_q.st == tfi_pkg::ST_IDLE) begin
            if (fill_v_i) begin
                s_d.tlb[s_q.rr] = '{valid: 1'b1, global: fill_global_i, leaf: fill_leaf_i,
                                    space: s_q.space, vpn: fill_vpn_i, ppn: fill_ppn_i};
                s_d.rr = PTR_W'((s_q.rr + 1'b1) % ENTRIES);
            end else begin
                s_d.pf = !fill_spec_i;
            end
        end
        // fence sequence
        unique case (s_q.st)
            tfi_pkg::ST_IDLE: begin
                if (fence_valid_i && dec.is_fence) begin
                    if (!PAGING) begin
                        s_d.illegal = 1'b1;
                    end else if (!dec.rs1_zero && !dec.va_ok) begin
                        s_d.done = 1'b1;
                    end else begin
                        s_d.use_va = !dec.rs1_zero && !s_q.ctrl[tfi_pkg::C_WIDE];
                        s_d.use_sp = !dec.rs2_zero && !s_q.ctrl[tfi_pkg::C_WIDE];
                        s_d.f_vpn  = dec.vpn;
                        s_d.f_sp   = dec.space;
                        s_d.st     = tfi_pkg::ST_DRAIN;
                    end
                end
            end
            tfi_pkg::ST_DRAIN: begin
                if (store_drained_i) begin
                    s_d.st = tfi_pkg::ST_FLUSH;
                end
            end
            tfi_pkg::ST_FLUSH: begin
                for (int i = 0; i < ENTRIES; i++) begin
                    if (f_kill(s_q.tlb[i], s_q.use_va, s_q.use_sp, s_q.f_vpn, s_q.f_sp)) begin
                        s_d.tlb[i].valid = 1'b0;
                    end
                end
                s_d.count = s_q.count + 16'h1;
                s_d.done  = 1'b1;
                s_d.st    = tfi_pkg::ST_IDLE;
            end
            default: s_d.st = tfi_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o                        = s_q.ack;
    assign wb_dat_o                        = s_q.rdata;
    assign fence_ready_o                   = s_q.st == tfi_pkg::ST_IDLE;
    assign stall_o                         = s_q.st != tfi_pkg::ST_IDLE;
    assign fence_done_o                    = s_q.done;
    assign illegal_o                       = s_q.illegal;
    assign lk_ready_o                      = s_q.st == tfi_pkg::ST_IDLE;
    assign lk_valid_o                      = s_q.lk_v;
    assign lk_hit_o                        = s_q.lk_hit;
    assign lk_ppn_o                        = s_q.lk_ppn;
    assign fill_ready_o                    = s_q.st == tfi_pkg::ST_IDLE;
    assign page_fault_o                    = s_q.pf;
    assign paged_o                         = s_q.ctrl[tfi_pkg::C_PAGED];
    assign supervisor_user_access_permit_o = s_q.ctrl[tfi_pkg::C_SUAP];
    assign make_executable_readable_o      = s_q.ctrl[tfi_pkg::C_MXR];
    assign space_o                         = s_q.space;

    property p_stall;
        @(posedge clk_i) disable iff (rst_i)
        (fence_valid_i && fence_ready_o && dec.is_fence && PAGING && (dec.rs1_zero || dec.va_ok))
        |=> stall_o && !lk_ready_o;
    endproperty
    a_stall: assert property (p_stall) else $error("fence accepted without stalling translation");

    property p_full;
        @(posedge clk_i) disable iff (rst_i)
        (s_q.st == tfi_pkg::ST_FLUSH && !s_q.use_va && !s_q.use_sp) |=> (valid_vec == '0);
    endproperty
    a_full: assert property (p_full) else $error("full fence left a valid entry");

    property p_global;
        @(posedge clk_i) disable iff (rst_i)
        (s_q.st == tfi_pkg::ST_FLUSH && s_q.use_sp) |=> (($past(gvalid_vec) & ~valid_vec) == '0);
    endproperty
    a_global: assert property (p_global) else $error("identifier fence removed a global entry");

    property p_badva;
        @(posedge clk_i) disable iff (rst_i)
        (fence_valid_i && fence_ready_o && dec.is_fence && PAGING && !dec.rs1_zero && !dec.va_ok)
        |=> fence_done_o && !stall_o && !illegal_o;
    endproperty
    a_badva: assert property (p_badva) else $error("bad address fence was not a silent no-op");

    property p_drain;
        @(posedge clk_i) disable iff (rst_i)
        (s_q.st == tfi_pkg::ST_DRAIN && !store_drained_i) |=> (s_q.st == tfi_pkg::ST_DRAIN) && !fence_done_o;
    endproperty
    a_drain: assert property (p_drain) else $error("invalidation ran before stores drained");

    property p_illegal;
        @(posedge clk_i) disable iff (rst_i)
        (fence_valid_i && fence_ready_o && dec.is_fence) |=> (illegal_o == !PAGING);
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal fence flag wrong for paging support");

    property p_ctrl;
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == tfi_pkg::A_CTRL && wb_sel_i[0])
        |=> (supervisor_user_access_permit_o == $past(wb_dat_i[tfi_pkg::C_SUAP]))
            && (make_executable_readable_o == $past(wb_dat_i[tfi_pkg::C_MXR]));
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control write did not act at once");

    property p_fault;
        @(posedge clk_i) disable iff (rst_i)
        (fill_valid_i && fill_ready_o && !fill_v_i) |=> (page_fault_o == !$past(fill_spec_i));
    endproperty
    a_fault: assert property (p_fault) else $error("page fault flag wrong for walk kind");

    property p_rd;
        @(posedge clk_i) disable iff (rst_i)
        (fence_valid_i && fence_ready_o && fence_instr_i[tfi_pkg::RD_HI:tfi_pkg::RD_LO] != tfi_pkg::REG_X0)
        |=> !stall_o && !fence_done_o && !illegal_o;
    endproperty
    a_rd: assert property (p_rd) else $error("instruction with nonzero rd taken as fence");
endmodule

//--- verification/tfi_walker_model.sv
// walker-side model that refills the translation cache
`timescale 1ns/1ps
module tfi_walker_model (
    // clock
    input  wire logic                      clk_i,
    // fill port
    input  wire logic                      fill_ready_i,
    output logic                           fill_valid_o = 1'b0,
    output logic      [tfi_pkg::VPN_W-1:0] fill_vpn_o = '0,
    output logic      [tfi_pkg::PPN_W-1:0] fill_ppn_o = '0,
    output logic                           fill_v_o = 1'b0,
    output logic                           fill_global_o = 1'b0,
    output logic                           fill_leaf_o = 1'b1,
    output logic                           fill_spec_o = 1'b0
);
    // fills come only from walks; invalid ones carry v low
    task automatic fill(input logic [26:0] vpn, input logic [43:0] ppn, input logic g, input logic v,
                        input logic l, input logic sp);
        @(posedge clk_i);
        fill_valid_o <= 1'b1;
        fill_vpn_o <= vpn;
        fill_ppn_o <= ppn;
        fill_global_o <= g;
        fill_v_o <= v;
        fill_leaf_o <= l;
        fill_spec_o <= sp;
        do @(posedge clk_i); while (fill_ready_i !== 1'b1);
        fill_valid_o <= 1'b0;
        fill_vpn_o <= ~vpn;
        fill_ppn_o <= ~ppn;
    endtask
endmodule

//--- verification/translation_fence_invalidate_tb.sv
// self-checking bench for the translation fence engine
`timescale 1ns/1ps
module translation_fence_invalidate_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o, fence_instr_i = '0, q;
    logic [63:0] fence_rs1_i = '0, fence_rs2_i = '0;
    logic fence_valid_i = 1'b0, store_drained_i = 1'b1, fence_ready_o, fence_done_o, illegal_o, stall_o;
    logic lk_valid_i = 1'b0, lk_ready_o, lk_valid_o, lk_hit_o, fill_valid_i, fill_v_i, fill_global_i;
    logic fill_spec_i, fill_ready_o, page_fault_o, paged_o, supervisor_user_access_permit_o;
    logic make_executable_readable_o;
    logic [26:0] lk_vpn_i = '0, fill_vpn_i;
    logic [43:0] lk_ppn_o, fill_ppn_i;
    logic [15:0] space_o;
    logic fill_leaf_i;
    int n_fail = 0, compares = 0;

    tfi_fence i_dut (.*);
    tfi_walker_model i_walk (.clk_i(clk_i), .fill_ready_i(fill_ready_o), .fill_valid_o(fill_valid_i),
        .fill_vpn_o(fill_vpn_i), .fill_ppn_o(fill_ppn_i), .fill_v_o(fill_v_i),
        .fill_global_o(fill_global_i), .fill_leaf_o(fill_leaf_i), .fill_spec_o(fill_spec_i));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic fence(input logic [6:0] f7, input logic [4:0] r1, input logic [4:0] r2,
                         input logic [63:0] v1, input logic [63:0] v2, input int drain);
        int k;
        @(posedge clk_i);
        fence_valid_i <= 1'b1;
        // 08 spoils only rd, a value with a bit set outside 09 spoils funct7
        fence_instr_i <= {f7 | 7'h09, r2, r1, 3'h0, 5'(f7 == 7'h08), 7'h73};
        fence_rs1_i <= v1;
        fence_rs2_i <= v2;
        store_drained_i <= (drain == 0);
        do @(posedge clk_i); while (fence_ready_o !== 1'b1);
        fence_valid_i <= (f7 != 7'h09);
        for (k = 0; k < drain; k++) begin
            @(posedge clk_i);
            chk("stall", 64'h1, stall_o);
            chk("lookup ready", 64'h0, lk_ready_o);
        end
        store_drained_i <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
            chk("illegal", 64'h0, illegal_o);
        end while (fence_done_o !== 1'b1 && k < 8);
        fence_valid_i <= 1'b0;
        chk("done", (f7 == 7'h09), fence_done_o);
    endtask

    task automatic look(input logic [26:0] v, input logic hit, input logic [43:0] ppn);
        @(posedge clk_i);
        lk_valid_i <= 1'b1;
        lk_vpn_i <= v;
        do @(posedge clk_i); while (lk_ready_o !== 1'b1);
        lk_valid_i <= 1'b0;
        @(posedge clk_i);
        chk("lookup valid", 64'h1, lk_valid_o);
        chk("lookup hit", hit, lk_hit_o);
        if (hit) chk("lookup ppn", ppn, lk_ppn_o);
    endtask

    task automatic complete_run;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        complete_run;
    end

    task automatic test_fill;
        wb(1'b0, 8'h00, '0);
        chk("ctrl reset", 64'h0, q);
        wb(1'b0, 8'h10, '0);
        chk("unmapped", 64'h0, q);
        wb(1'b1, 8'h00, 32'h7);
        chk("paged", 64'h1, paged_o);
        chk("user access", 64'h1, supervisor_user_access_permit_o);
        chk("exec readable", 64'h1, make_executable_readable_o);
        wb(1'b0, 8'h00, '0);
        chk("ctrl read", 64'h7, q);
        wb(1'b1, 8'h04, 32'h5);
        chk("space now", 64'h5, space_o);
        i_walk.fill(27'h1, 44'h11, 1'b0, 1'b1, 1'b1, 1'b0);
        i_walk.fill(27'h2, 44'h22, 1'b1, 1'b1, 1'b1, 1'b0);
        wb(1'b1, 8'h04, 32'h6);
        i_walk.fill(27'h3, 44'h33, 1'b0, 1'b1, 1'b1, 1'b0);
        i_walk.fill(27'h2, 44'h99, 1'b0, 1'b1, 1'b0, 1'b0);
        i_walk.fill(27'h6, 44'h66, 1'b0, 1'b0, 1'b1, 1'b0);
        @(posedge clk_i);
        chk("page fault", 64'h1, page_fault_o);
        i_walk.fill(27'h8, 44'h88, 1'b0, 1'b0, 1'b1, 1'b1);
        @(posedge clk_i);
        chk("speculative fault", 64'h0, page_fault_o);
        look(27'h1, 1'b0, '0);
        look(27'h2, 1'b1, 44'h22);
        look(27'h6, 1'b0, '0);
        $display("test fill done");
    endtask

    task automatic test_targeted;
        fence(7'h08, 5'h0, 5'h0, '0, '0, 0);
        fence(7'h0a, 5'h0, 5'h0, '0, '0, 0);
        look(27'h3, 1'b1, 44'h33);
        wb(1'b1, 8'h04, 32'h5);
        look(27'h1, 1'b1, 44'h11);
        fence(7'h09, 5'h0, 5'h2, '0, '0, 0);
        look(27'h2, 1'b1, 44'h22);
        fence(7'h09, 5'h0, 5'h2, '0, 64'hffff_ffff_0000_0005, 2);
        look(27'h1, 1'b0, '0);
        look(27'h2, 1'b1, 44'h22);
        wb(1'b1, 8'h04, 32'h6);
        look(27'h3, 1'b1, 44'h33);
        fence(7'h09, 5'h1, 5'h0, 64'h0000_0040_0000_3000, '0, 0);
        look(27'h3, 1'b1, 44'h33);
        fence(7'h09, 5'h1, 5'h0, 64'h2000, '0, 0);
        look(27'h2, 1'b0, '0);
        i_walk.fill(27'h4, 44'h44, 1'b1, 1'b1, 1'b1, 1'b0);
        fence(7'h09, 5'h1, 5'h2, 64'h4000, 64'h6, 1);
        look(27'h4, 1'b1, 44'h44);
        fence(7'h09, 5'h1, 5'h2, 64'h3000, 64'h6, 0);
        look(27'h3, 1'b0, '0);
        wb(1'b0, 8'h08, '0);
        chk("status", 64'h30, q);
        $display("test targeted fences done");
    endtask

    task automatic test_full;
        wb(1'b1, 8'h00, 32'hf);
        fence(7'h09, 5'h1, 5'h2, 64'h9000, 64'h6, 0);
        look(27'h4, 1'b0, '0);
        wb(1'b1, 8'h00, 32'h7);
        i_walk.fill(27'h5, 44'h55, 1'b0, 1'b1, 1'b1, 1'b0);
        look(27'h5, 1'b1, 44'h55);
        fence(7'h09, 5'h0, 5'h0, '0, '0, 3);
        look(27'h5, 1'b0, '0);
        wb(1'b1, 8'h00, 32'h0);
        look(27'h7, 1'b1, 44'h7);
        wb(1'b0, 8'h0c, '0);
        chk("fence count", 64'h7, q);
        $display("test full fence done");
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        test_fill;
        test_targeted;
        test_full;
        complete_run;
    end
endmodule
